// ### scis_cfg_src.sv
`timescale 1ns/1ps
module scis_cfg_src (
    // wires seen by the source
    input  wire logic status_w,
    input  wire logic cs_n,
    input  wire logic bad_crc,
    // serial link
    output logic      sdata,
    output logic      sclk
);
    logic [1023:0] img;
    function automatic logic [1023:0] build(input logic corrupt);
        logic [15:0]   crc;
        logic [1023:0] v;
        crc = scis_pkg::CRC_INIT;
        for (int i = 0; i < 1008; i++) begin
            v[1023 - i] = i[0] ^ i[3] ^ i[6];
            crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ v[1023 - i]) ? scis_pkg::CRC_POLY : 16'h0);
        end
        v[15:0] = crc ^ {15'h0, corrupt};
        return v;
    endfunction
    initial begin
        sclk  = 1'b0;
        sdata = 1'b1;
        forever begin
            wait (status_w === 1'b1 && cs_n === 1'b0);
            // 5 ns off the core clock edges, so pin sampling never races the model
            #105;
            img = build(bad_crc);
            for (int i = 1023; i >= 0; i--) begin
                if (status_w !== 1'b1 || cs_n !== 1'b0) break;
                sdata = img[i];
                #40 sclk = 1'b1;
                #80 sclk = 1'b0;
                #40;
            end
            // line released: never leave the last bit looking valid
            sdata = ~sdata;
            wait (status_w !== 1'b1 || cs_n !== 1'b0);
        end
    end
endmodule // scis_cfg_src

// ### scis_config_init.sv
`timescale 1ns/1ps
module scis_config_init (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    // configuration link pins
    input  wire logic               config_status_n_in,
    output scis_pkg::scis_od_s      config_status_n,
    input  wire logic               serial_config_data,
    input  wire logic               config_shift_clock,
    input  wire logic               config_complete_flag_in,
    output scis_pkg::scis_od_s      config_complete_flag,
    // initialization pins
    input  wire logic               user_startup_clock,
    input  wire logic               init_complete_in,
    output scis_pkg::scis_od_s      init_complete,
    // option straps
    input  wire logic               use_user_clock,
    input  wire logic               init_complete_enable,
    // status
    output logic                    user_mode,
    output logic                    config_error
);

    // synchronised pin levels and edges
    logic status_lvl;
    logic data_lvl;
    logic shift_rise;
    logic complete_rise;
    logic usr_rise;
    logic sel_lvl;
    logic ena_lvl;

    scis_sync_edge u_sync_status (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .async_in (config_status_n_in),
        .level    (status_lvl),
        .rise     ()
    );

    // data and shift clock share the same latency, so they stay aligned
    scis_sync_edge u_sync_data (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .async_in (serial_config_data),
        .level    (data_lvl),
        .rise     ()
    );

    scis_sync_edge u_sync_shift (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .async_in (config_shift_clock),
        .level    (),
        .rise     (shift_rise)
    );

    scis_sync_edge u_sync_complete (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .async_in (config_complete_flag_in),
        .level    (),
        .rise     (complete_rise)
    );

    // sampled at 50 MHz: user clock edges beyond 25 MHz are lost here
    scis_sync_edge u_sync_usr (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .async_in (user_startup_clock),
        .level    (),
        .rise     (usr_rise)
    );

    scis_sync_edge u_sync_sel (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .async_in (use_user_clock),
        .level    (sel_lvl),
        .rise     ()
    );

    scis_sync_edge u_sync_ena (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .async_in (init_complete_enable),
        .level    (ena_lvl),
        .rise     ()
    );

    // internal oscillator stand-in, free running
    logic [scis_pkg::OSC_CNT_W-1:0] osc_cnt;
    logic [scis_pkg::OSC_CNT_W-1:0] next_osc_cnt;
    logic                           osc_tick;

    always_comb begin
        if (osc_cnt == scis_pkg::OSC_CNT_W'(scis_pkg::OSC_DIV - 1)) begin
            next_osc_cnt = '0;
        end else begin
            next_osc_cnt = osc_cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            osc_cnt <= '0;
        end else begin
            osc_cnt <= next_osc_cnt;
        end
    end

    assign osc_tick = (osc_cnt == '0);

    // sequencer state
    scis_pkg::scis_state_e            state;
    scis_pkg::scis_state_e            next_state;
    logic [scis_pkg::BIT_CNT_W-1:0]   bit_cnt;
    logic [scis_pkg::BIT_CNT_W-1:0]   next_bit_cnt;
    logic [15:0]                      crc;
    logic [15:0]                      next_crc;
    logic [15:0]                      chk;
    logic [15:0]                      next_chk;
    logic [scis_pkg::INIT_CNT_W-1:0]  init_cnt;
    logic [scis_pkg::INIT_CNT_W-1:0]  next_init_cnt;
    logic                             clk_sel;
    logic                             next_clk_sel;
    logic                             od_ena;
    logic                             next_od_ena;
    scis_pkg::scis_od_s               next_status_od;
    scis_pkg::scis_od_s               next_complete_od;
    scis_pkg::scis_od_s               next_init_od;
    logic                             next_user_mode;
    logic                             next_config_error;
    logic                             init_tick;
    logic                             crc_fb;

    // user clock is only looked at in ST_INIT, never during loading
    assign init_tick = clk_sel ? usr_rise : osc_tick;
    assign crc_fb    = crc[15] ^ data_lvl;

    always_comb begin
        next_state        = state;
        next_bit_cnt      = bit_cnt;
        next_crc          = crc;
        next_chk          = chk;
        next_init_cnt     = init_cnt;
        next_clk_sel      = clk_sel;
        next_od_ena       = od_ena;
        next_status_od    = config_status_n;
        next_complete_od  = config_complete_flag;
        next_init_od      = init_complete;
        next_user_mode    = user_mode;
        next_config_error = config_error;
        case (state)
            scis_pkg::ST_IDLE: begin
                next_status_od   = scis_pkg::OD_RELEASE;
                next_complete_od = scis_pkg::OD_DRIVE_LOW;
                next_od_ena      = ena_lvl;
                next_init_od     = ena_lvl ? scis_pkg::OD_DRIVE_LOW
                                           : scis_pkg::OD_RELEASE;
                next_bit_cnt     = '0;
                next_crc         = scis_pkg::CRC_INIT;
                next_chk         = '0;
                if (status_lvl) begin
                    next_state = scis_pkg::ST_LOAD;
                end
            end
            scis_pkg::ST_LOAD: begin
                if (!status_lvl) begin
                    // status pulled low by someone else: start over
                    next_state = scis_pkg::ST_IDLE;
                end else if (shift_rise) begin
                    next_chk     = {chk[14:0], data_lvl};
                    next_bit_cnt = bit_cnt + 1'b1;
                    if (bit_cnt < scis_pkg::BIT_CNT_W'(scis_pkg::PAYLOAD_BITS)) begin
                        next_crc = {crc[14:0], 1'b0} ^ (crc_fb ? scis_pkg::CRC_POLY : 16'h0000);
                    end
                    if (bit_cnt == scis_pkg::BIT_CNT_W'(scis_pkg::BITSTREAM_BITS - 1)) begin
                        if ({chk[14:0], data_lvl} == crc) begin
                            next_complete_od = scis_pkg::OD_RELEASE;
                            next_state       = scis_pkg::ST_RELEASE;
                        end else begin
                            next_status_od    = scis_pkg::OD_DRIVE_LOW;
                            next_config_error = 1'b1;
                            next_state        = scis_pkg::ST_ERROR;
                        end
                    end
                end
            end
            scis_pkg::ST_RELEASE: begin
                // line rises only once the pull-up wins; source then idles
                if (complete_rise) begin
                    next_clk_sel  = sel_lvl;
                    next_init_cnt = '0;
                    next_state    = scis_pkg::ST_INIT;
                end
            end
            scis_pkg::ST_INIT: begin
                if (init_tick) begin
                    next_init_cnt = init_cnt + 1'b1;
                    if (init_cnt == scis_pkg::INIT_CNT_W'(scis_pkg::INIT_CYCLES - 1)) begin
                        next_init_od   = scis_pkg::OD_RELEASE;
                        next_user_mode = 1'b1;
                        next_state     = scis_pkg::ST_USER;
                    end
                end
            end
            scis_pkg::ST_USER: begin
                next_user_mode = 1'b1;
            end
            scis_pkg::ST_ERROR: begin
                // stays failed until reset reloads
                next_status_od = scis_pkg::OD_DRIVE_LOW;
            end
            default: begin
                next_state = scis_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state                <= scis_pkg::ST_IDLE;
            bit_cnt              <= '0;
            crc                  <= scis_pkg::CRC_INIT;
            chk                  <= '0;
            init_cnt             <= '0;
            clk_sel              <= 1'b0;
            od_ena               <= 1'b0;
            config_status_n      <= scis_pkg::OD_DRIVE_LOW;
            config_complete_flag <= scis_pkg::OD_DRIVE_LOW;
            init_complete        <= scis_pkg::OD_RELEASE;
            user_mode            <= 1'b0;
            config_error         <= 1'b0;
        end else begin
            state                <= next_state;
            bit_cnt              <= next_bit_cnt;
            crc                  <= next_crc;
            chk                  <= next_chk;
            init_cnt             <= next_init_cnt;
            clk_sel              <= next_clk_sel;
            od_ena               <= next_od_ena;
            config_status_n      <= next_status_od;
            config_complete_flag <= next_complete_od;
            init_complete        <= next_init_od;
            user_mode            <= next_user_mode;
            config_error         <= next_config_error;
        end
    end

    // readback of init-complete pin is not needed for sequencing
    logic unused_init_in;
    assign unused_init_in = init_complete_in & od_ena;

endmodule // scis_config_init

// ### scis_config_init_checker.sv
`timescale 1ns/1ps
module scis_config_init_checker (
    // clock and reset
    input wire logic               core_clk,
    input wire logic               sys_rst,
    // link and init pins
    input wire logic               config_status_n_in,
    input wire scis_pkg::scis_od_s config_status_n,
    input wire logic               serial_config_data,
    input wire logic               config_shift_clock,
    input wire logic               config_complete_flag_in,
    input wire scis_pkg::scis_od_s config_complete_flag,
    input wire logic               user_startup_clock,
    input wire logic               init_complete_in,
    input wire scis_pkg::scis_od_s init_complete,
    // straps and status
    input wire logic               use_user_clock,
    input wire logic               init_complete_enable,
    input wire logic               user_mode,
    input wire logic               config_error
);
    logic [15:0] cpl_age;
    logic [15:0] s_age;
    logic [8:0]  u_cnt;
    logic [3:0]  rel;
    logic        cpl_q;
    logic        s_q;
    logic        u_q;
    // ages are taken from pin edges, so the design's sync delay sits inside the windows
    always_ff @(posedge core_clk) begin
        cpl_q   <= config_complete_flag_in;
        s_q     <= config_shift_clock;
        u_q     <= user_startup_clock;
        cpl_age <= (config_complete_flag_in && !cpl_q) ? 16'h0 : cpl_age + 16'h1;
        s_age   <= (config_shift_clock && !s_q) ? 16'h0 : s_age + 16'h1;
        u_cnt   <= (config_complete_flag_in && !cpl_q) ? 9'h0
                 : u_cnt + 9'(user_startup_clock && !u_q);
        rel     <= sys_rst ? 4'h0 : ((rel == 4'hf) ? rel : rel + 4'h1);
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    property p_done_hold;
        config_complete_flag.oe_n |=> config_complete_flag.oe_n;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("completion line dropped");
    property p_done_after_bit;
        $rose(config_complete_flag.oe_n) |-> s_age inside {[2:6]};
    endproperty
    a_done_after_bit: assert property (p_done_after_bit) else $error("release not on shift");
    property p_err_low;
        config_error |-> !config_complete_flag.oe_n && !config_status_n.oe_n;
    endproperty
    a_err_low: assert property (p_err_low) else $error("completion released on error");
    property p_user_after_done;
        user_mode |-> config_complete_flag_in && !config_error;
    endproperty
    a_user_after_done: assert property (p_user_after_done) else $error("user mode early");
    property p_user_stays;
        user_mode |=> user_mode;
    endproperty
    a_user_stays: assert property (p_user_stays) else $error("user mode dropped");
    property p_init_rel;
        user_mode |-> init_complete.oe_n;
    endproperty
    a_init_rel: assert property (p_init_rel) else $error("init pin held in user mode");
    property p_init_low;
        rel == 4'hf && init_complete_enable && !user_mode |-> !init_complete.oe_n;
    endproperty
    a_init_low: assert property (p_init_low) else $error("init pin released early");
    property p_osc_count;
        $rose(user_mode) && !use_user_clock |-> cpl_age inside {[1492:1503]};
    endproperty
    a_osc_count: assert property (p_osc_count) else $error("internal init length");
    property p_user_count;
        $rose(user_mode) && use_user_clock |-> u_cnt inside {[299:300]};
    endproperty
    a_user_count: assert property (p_user_count) else $error("user clock init length");
endmodule // scis_config_init_checker

bind scis_config_init scis_config_init_checker i_scis_config_init_checker (
    .core_clk(core_clk), .sys_rst(sys_rst), .config_status_n_in(config_status_n_in),
    .config_status_n(config_status_n), .serial_config_data(serial_config_data),
    .config_shift_clock(config_shift_clock), .config_complete_flag_in(config_complete_flag_in),
    .config_complete_flag(config_complete_flag), .user_startup_clock(user_startup_clock),
    .init_complete_in(init_complete_in), .init_complete(init_complete),
    .use_user_clock(use_user_clock), .init_complete_enable(init_complete_enable),
    .user_mode(user_mode), .config_error(config_error));

// ### scis_config_init_tb.sv
`timescale 1ns/1ps
module scis_config_init_tb;
    logic               core_clk;
    logic               sys_rst;
    logic               uclk;
    logic               use_uclk;
    logic               init_en;
    logic               bad_crc;
    logic               sdata;
    logic               sclk;
    logic               user_mode;
    logic               config_error;
    logic               st_w;
    logic               cpl_w;
    logic               ini_w;
    scis_pkg::scis_od_s st_d;
    scis_pkg::scis_od_s cpl_d;
    scis_pkg::scis_od_s ini_d;
    int                 num_errors = 0;
    int                 num_checks = 0;
    // pull-ups win whenever the drivers let go
    assign st_w  = st_d.oe_n;
    assign cpl_w = cpl_d.oe_n;
    assign ini_w = ini_d.oe_n;
    scis_config_init i_scis_config_init (
        .core_clk(core_clk), .sys_rst(sys_rst), .config_status_n_in(st_w),
        .config_status_n(st_d), .serial_config_data(sdata), .config_shift_clock(sclk),
        .config_complete_flag_in(cpl_w), .config_complete_flag(cpl_d),
        .user_startup_clock(uclk), .init_complete_in(ini_w), .init_complete(ini_d),
        .use_user_clock(use_uclk), .init_complete_enable(init_en),
        .user_mode(user_mode), .config_error(config_error));
    scis_cfg_src i_scis_cfg_src (
        .status_w(st_w), .cs_n(cpl_w), .bad_crc(bad_crc), .sdata(sdata), .sclk(sclk));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        if (num_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic start(input logic u, input logic en, input logic bad);
        sys_rst  <= 1'b1;
        use_uclk <= u;
        init_en  <= en;
        bad_crc  <= bad;
        uclk     <= 1'b0;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
    endtask
    task automatic wait_hi(ref logic s, input int lim);
        for (int n = 0; s !== 1'b1 && n < lim; n++) @(posedge core_clk);
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            uclk <= 1'b1;
            repeat (5) @(posedge core_clk);
            uclk <= 1'b0;
            repeat (5) @(posedge core_clk);
        end
    endtask
    task automatic t_internal();
        int n;
        start(1'b0, 1'b1, 1'b0);
        wait_hi(cpl_w, 9000);
        check("complete wire", cpl_w, 1'b1);
        check("config error", config_error, 1'b0);
        for (n = 0; user_mode !== 1'b1 && n < 1600; n++) begin
            if (ini_w !== 1'b0) check("init wire low", ini_w, 1'b0);
            @(posedge core_clk);
        end
        check("init length ok", 16'(n >= 1492 && n <= 1503), 16'h1);
        check("init wire high", ini_w, 1'b1);
    endtask
    task automatic t_bad();
        start(1'b0, 1'b1, 1'b0);
        repeat (2000) @(posedge core_clk);
        // reset in mid-frame, then a frame with a broken check word
        start(1'b0, 1'b1, 1'b1);
        wait_hi(config_error, 9000);
        check("config error", config_error, 1'b1);
        check("complete wire", cpl_w, 1'b0);
        repeat (1600) @(posedge core_clk);
        check("user mode", user_mode, 1'b0);
        check("init wire low", ini_w, 1'b0);
    endtask
    task automatic t_user();
        start(1'b1, 1'b0, 1'b0);
        repeat (300) @(posedge core_clk);
        pulses(20);
        wait_hi(cpl_w, 9000);
        check("complete wire", cpl_w, 1'b1);
        repeat (1600) @(posedge core_clk);
        check("user mode held", user_mode, 1'b0);
        pulses(298);
        check("user mode 298", user_mode, 1'b0);
        pulses(1);
        check("user mode 299", user_mode, 1'b1);
    endtask
    initial begin
        t_internal();
        t_bad();
        t_user();
        final_report();
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        num_errors++;
        final_report();
    end
endmodule // scis_config_init_tb

// ### scis_pkg.sv
// Operation
// - sample data on config shift clock rise
// - release completion line after error-free load
// - completion line rise starts initialization
// - internal oscillator default, user clock optional
// - internal oscillator supplies init cycles unless user clock is selected
// - user clock mode advances only on edges
// - user clock ignored during configuration
// - count 299 init cycles, user clock limit; the user clock is sampled at 50 MHz, so its edges beyond 25 MHz are lost
// - init-complete output rises at user mode
package scis_pkg;

    // core timing
    localparam int unsigned CORE_CLK_HZ     = 50_000_000;
    localparam int unsigned INT_OSC_HZ      = 10_000_000;
    localparam int unsigned OSC_DIV         = CORE_CLK_HZ / INT_OSC_HZ;
    localparam int unsigned USER_CLK_MAX_HZ = 100_000_000;
    localparam int unsigned INIT_CYCLES     = 299;

    // bitstream layout: payload followed by a check word
    localparam int unsigned BITSTREAM_BITS  = 1024;
    localparam int unsigned CHECK_BITS      = 16;
    localparam int unsigned PAYLOAD_BITS    = BITSTREAM_BITS - CHECK_BITS;
    localparam logic [15:0] CRC_POLY        = 16'h1021;
    localparam logic [15:0] CRC_INIT        = 16'hffff;

    // counter widths
    localparam int unsigned BIT_CNT_W       = 16;
    localparam int unsigned INIT_CNT_W      = 9;
    localparam int unsigned OSC_CNT_W       = 3;

    typedef enum {
        ST_IDLE,
        ST_LOAD,
        ST_RELEASE,
        ST_INIT,
        ST_USER,
        ST_ERROR
    } scis_state_e;

    // open-drain pin drive: oe_n low while the pin is pulled low
    typedef struct packed {
        logic out;
        logic oe_n;
    } scis_od_s;

    localparam scis_od_s OD_DRIVE_LOW = '{out: 1'b0, oe_n: 1'b0};
    localparam scis_od_s OD_RELEASE   = '{out: 1'b0, oe_n: 1'b1};

endpackage

// ### scis_sync_edge.sv
`timescale 1ns/1ps
module scis_sync_edge (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // asynchronous input
    input  wire logic async_in,
    // synchronised results
    output logic      level,
    output logic      rise
);

    logic meta;
    logic stage2;
    logic stage3;
    logic next_meta;
    logic next_stage2;
    logic next_stage3;

    always_comb begin
        next_meta   = async_in;
        next_stage2 = meta;
        next_stage3 = stage2;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            meta   <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            meta   <= next_meta;
            stage2 <= next_stage2;
            stage3 <= next_stage3;
        end
    end

    // edge taken from the settled stages only, never from meta
    assign level = stage2;
    assign rise  = stage2 & ~stage3;

endmodule // scis_sync_edge
